// File: rtl/adc_seq_pkg.sv
// Shared constants and types for the converter control sequencer
package adc_seq_pkg;

    // ************************************************
    // Register indices, byte address is four times
    // ************************************************
    localparam logic [14:0] IDX_CONTROL = 15'h7f20;
    localparam logic [14:0] IDX_MODE = 15'h7f21;
    localparam logic [14:0] IDX_RES_LOW = 15'h7f22;
    localparam logic [14:0] IDX_RES_HIGH = 15'h7f23;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int CTL_SEL_LO = 4;
    localparam int CTL_CMP = 3;
    localparam int CTL_START = 2;
    localparam int CTL_DONE = 1;
    localparam int CTL_IE = 0;
    localparam int MODE_RESOLUTION_SELECT = 6;
    localparam int MODE_OFFS = 2;
    localparam int MODE_DIV_LO = 0;
    localparam int LOW_NIB_LO = 4;
    localparam int LOW_CMP = 3;
    localparam int LOW_DIV = 0;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_LOW = 8'h00;
    localparam logic [7:0] RST_HIGH = 8'h00;

    // ************************************************
    // Timing, conversion figures in cycle-clock periods
    // ************************************************
    localparam int TCYC_NS = 10;
    localparam int CLK_NS = 10;
    localparam int CLK_PER_TCYC = TCYC_NS / CLK_NS;
    localparam logic [7:0] CYC_BASE_12 = 8'(52 * CLK_PER_TCYC);
    localparam logic [7:0] CYC_BASE_8 = 8'(32 * CLK_PER_TCYC);
    localparam logic [7:0] CYC_BASE_CMP = 8'(28 * CLK_PER_TCYC);
    localparam logic [7:0] CYC_EXTRA = 8'(2 * CLK_PER_TCYC);
    localparam logic [2:0] TRIAL_LAST = 3'h5;
    localparam logic [11:0] SAR_INIT = 12'h800;
    localparam logic [3:0] SAR_MSB = 4'hb;
    localparam logic [3:0] SAR_LSB_8 = 4'h4;
    localparam logic [3:0] SAR_LSB_12 = 4'h0;

    typedef enum logic {ST_IDLE, ST_RUN} seq_state_t;

endpackage

// File: rtl/conv_time_calc.sv
// Conversion length from divider code, resolution and mode
`timescale 1ns/1ps
`default_nettype none
module conv_time_calc (
    input wire logic [2:0] div_code, // Divider code, ratio 1/2^code
    input wire logic eight_bit, // 8-bit resolution selected
    input wire logic compare, // Compare mode selected
    input wire logic doubled, // First 12-bit conversion
    output logic [7:0] length // Cycles the operation lasts
);
    logic [7:0] base;
    logic [8:0] sum;
    logic [7:0] single;

    assign base = compare ? adc_seq_pkg::CYC_BASE_CMP :
        (eight_bit ? adc_seq_pkg::CYC_BASE_8 : adc_seq_pkg::CYC_BASE_12);
    // Round the division up so no operation is cut short
    assign sum = {1'b0, base} + ((9'h001 << div_code) - 9'h001);
    assign single = 8'(sum >> div_code) + adc_seq_pkg::CYC_EXTRA;
    assign length = doubled ? {single[6:0], 1'b0} : single;
endmodule // conv_time_calc
`default_nettype wire

// File: rtl/sar_engine.sv
// Successive approximation register driving the ladder code
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
    input wire logic clk, // System cycle clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic start, // Begin an operation
    input wire logic hold, // Load preset and run no trials
    input wire logic eight_bit, // Stop after eight trials
    input wire logic [11:0] preset, // Code used in compare mode
    input wire logic comp_bit, // Filtered comparator, input above ref
    output logic [11:0] code // Ladder code
);
    logic [3:0] bit_idx;
    logic [3:0] last_idx;
    logic [2:0] phase;
    logic busy;
    logic trial_end;

    // Each trial waits for the comparator filter to settle
    assign trial_end = busy & (phase == adc_seq_pkg::TRIAL_LAST);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            code <= 12'h000;
            bit_idx <= adc_seq_pkg::SAR_MSB;
            last_idx <= adc_seq_pkg::SAR_LSB_12;
            phase <= 3'h0;
            busy <= 1'b0;
        end else if (ce) begin
            if (start) begin
                code <= hold ? preset : adc_seq_pkg::SAR_INIT;
                bit_idx <= adc_seq_pkg::SAR_MSB;
                last_idx <= eight_bit ? adc_seq_pkg::SAR_LSB_8 :
                    adc_seq_pkg::SAR_LSB_12;
                phase <= 3'h0;
                busy <= ~hold;
            end else if (busy) begin
                phase <= trial_end ? 3'h0 : phase + 3'h1;
                if (trial_end) begin
                    code[bit_idx] <= comp_bit;
                    if (bit_idx == last_idx) begin
                        busy <= 1'b0;
                    end else begin
                        code[bit_idx - 4'h1] <= 1'b1;
                        bit_idx <= bit_idx - 4'h1;
                    end
                end
            end
        end
    end

    property p_trial;
        @(posedge clk) disable iff (!rst_b)
        trial_end && ce && !start |=> code[$past(bit_idx)] == $past(comp_bit);
    endproperty
    a_trial: assert property (p_trial)
        else $error("trial bit does not follow comparator");
endmodule // sar_engine
`default_nettype wire

// File: rtl/adc_control_sequencer.sv
// Control sequencer for the 16-input successive approximation converter
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer (
    input wire logic clk, // System cycle clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic [16:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    input wire logic [3:0] byteenable, // Avalon byte enables
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait request
    input wire logic comp_out, // Comparator output, asynchronous
    output logic [3:0] channel_sel, // Input multiplexer select
    output logic ladder_enable, // Reference ladder enable
    output logic [11:0] ladder_code, // Ladder multiplexer code
    output logic offset_comp, // Offset compensation enable
    output logic result_strobe, // Result capture pulse
    output logic irq // Interrupt request
);

    // ************************************************
    // Declarations
    // ************************************************
    adc_seq_pkg::seq_state_t state;
    adc_seq_pkg::seq_state_t next_state;
    logic bus_ack;
    logic commit;
    logic sel_ctl;
    logic sel_mode;
    logic sel_low;
    logic sel_high;
    logic wr_ctl;
    logic wr_mode;
    logic wr_low;
    logic wr_high;
    logic [7:0] wd;
    logic [7:0] rd_byte;
    logic [7:0] ctl_rd;
    logic [7:0] mode_rd;
    logic [7:0] low_rd;
    logic [3:0] input_select;
    logic compare_mode_select;
    logic done_flag;
    logic irq_enable;
    logic resolution_select;
    logic offset_comp_enable;
    logic [1:0] divider_low_bits;
    logic divider_high_bit;
    logic [3:0] result_low_nibble;
    logic [7:0] adc_result_high;
    logic running;
    logic start_req;
    logic abort;
    logic finish;
    logic [7:0] count;
    logic [7:0] load_len;
    logic op_cmp;
    logic op_resolution_select;
    logic first_pending;
    logic doubled;
    logic comp_s1;
    logic comp_s2;
    logic comp_s3;
    logic comp_q;
    logic comp_level;
    logic [7:0] run_len;
    logic [7:0] op_len;

    function automatic logic hit(input logic [16:0] a,
                                 input logic [14:0] idx);
        hit = (a[16:2] == idx);
    endfunction

    // ************************************************
    // Avalon slave, one wait cycle on every access
    // ************************************************
    assign waitrequest = (read | write) & ~bus_ack;
    assign wd = writedata[7:0];
    assign sel_ctl = hit(address, adc_seq_pkg::IDX_CONTROL);
    assign sel_mode = hit(address, adc_seq_pkg::IDX_MODE);
    assign sel_low = hit(address, adc_seq_pkg::IDX_RES_LOW);
    assign sel_high = hit(address, adc_seq_pkg::IDX_RES_HIGH);
    assign commit = write & bus_ack & byteenable[0];
    assign wr_ctl = commit & sel_ctl;
    assign wr_mode = commit & sel_mode;
    assign wr_low = commit & sel_low;
    assign wr_high = commit & sel_high;

    // Reserved bits read as zero
    assign ctl_rd = {input_select, compare_mode_select, running,
                     done_flag, irq_enable};
    assign mode_rd = {1'b0, resolution_select, 3'b000,
                      offset_comp_enable, divider_low_bits};
    assign low_rd = {result_low_nibble, 3'b000,
                     divider_high_bit};
    assign rd_byte = sel_ctl ? ctl_rd :
                     sel_mode ? mode_rd :
                     sel_low ? low_rd :
                     sel_high ? adc_result_high : 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_ack <= 1'b0;
        end else if (ce) begin
            bus_ack <= (read | write) & ~bus_ack;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            readdata <= 32'h00000000;
        end else if (ce && read && !bus_ack) begin
            readdata <= {24'h000000, rd_byte};
        end
    end

    // ************************************************
    // Comparator filter, three stages
    // ************************************************
    assign comp_level = (comp_s2 == comp_s3) ? comp_s3 : comp_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
            comp_s3 <= 1'b0;
            comp_q <= 1'b0;
        end else if (ce) begin
            comp_s1 <= comp_out;
            comp_s2 <= comp_s1;
            comp_s3 <= comp_s2;
            comp_q <= comp_level;
        end
    end

    // ************************************************
    // Operation sequencing
    // ************************************************
    assign running = (state == adc_seq_pkg::ST_RUN);
    assign start_req = wr_ctl & wd[adc_seq_pkg::CTL_START]
                       & ~running;
    assign finish = running & (count == 8'h01);
    // A clear in the finishing cycle loses to completion
    assign abort = wr_ctl & ~wd[adc_seq_pkg::CTL_START] & running
                   & ~finish;
    assign doubled = first_pending & ~resolution_select
                     & ~wd[adc_seq_pkg::CTL_CMP];

    always_comb begin
        case (state)
            adc_seq_pkg::ST_IDLE: begin
                next_state = start_req ? adc_seq_pkg::ST_RUN :
                    adc_seq_pkg::ST_IDLE;
            end
            adc_seq_pkg::ST_RUN: begin
                next_state = (finish | abort) ? adc_seq_pkg::ST_IDLE :
                    adc_seq_pkg::ST_RUN;
            end
            default: begin
                next_state = adc_seq_pkg::ST_IDLE;
            end
        endcase
    end

    conv_time_calc u_calc (
        .div_code({divider_high_bit, divider_low_bits}),
        .eight_bit(resolution_select),
        .compare(wd[adc_seq_pkg::CTL_CMP]),
        .doubled(doubled),
        .length(load_len)
    );

    sar_engine u_sar (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .start(start_req),
        .hold(wd[adc_seq_pkg::CTL_CMP]),
        .eight_bit(resolution_select),
        .preset({adc_result_high, 4'h0}),
        .comp_bit(comp_level),
        .code(ladder_code)
    );

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state <= adc_seq_pkg::ST_IDLE;
            count <= 8'h00;
            op_cmp <= 1'b0;
            op_resolution_select <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            if (start_req) begin
                count <= load_len;
                op_cmp <= wd[adc_seq_pkg::CTL_CMP];
                op_resolution_select <= resolution_select;
            end else if (running) begin
                count <= count - 8'h01;
            end
        end
    end

    // Pending until a 12-bit conversion starts, rearmed by 8-bit mode
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            first_pending <= 1'b1;
        end else if (ce) begin
            if (resolution_select) begin
                first_pending <= 1'b1;
            end else if (start_req && !wd[adc_seq_pkg::CTL_CMP]) begin
                first_pending <= 1'b0;
            end
        end
    end

    // ************************************************
    // Control and mode registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            input_select <= adc_seq_pkg::RST_CONTROL[7:4];
            compare_mode_select <= adc_seq_pkg::RST_CONTROL[3];
            done_flag <= adc_seq_pkg::RST_CONTROL[1];
            irq_enable <= adc_seq_pkg::RST_CONTROL[0];
        end else if (ce) begin
            if (wr_ctl) begin
                input_select <= wd[adc_seq_pkg::CTL_SEL_LO +: 4];
                compare_mode_select <= wd[adc_seq_pkg::CTL_CMP];
                irq_enable <= wd[adc_seq_pkg::CTL_IE];
            end
            if (finish) begin
                done_flag <= 1'b1;
            end else if (wr_ctl && !wd[adc_seq_pkg::CTL_DONE]) begin
                done_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            resolution_select <= adc_seq_pkg::RST_MODE[6];
            offset_comp_enable <= adc_seq_pkg::RST_MODE[2];
            divider_low_bits <= adc_seq_pkg::RST_MODE[1:0];
        end else if (ce && wr_mode) begin
            resolution_select <= wd[adc_seq_pkg::MODE_RESOLUTION_SELECT];
            offset_comp_enable <= wd[adc_seq_pkg::MODE_OFFS];
            divider_low_bits <= wd[adc_seq_pkg::MODE_DIV_LO +: 2];
        end
    end

    // ************************************************
    // Result registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            result_low_nibble <= adc_seq_pkg::RST_LOW[7:4];
            divider_high_bit <= adc_seq_pkg::RST_LOW[0];
        end else if (ce) begin
            if (finish && op_cmp) begin
                result_low_nibble[adc_seq_pkg::LOW_CMP] <=
                    comp_level;
            end else if (finish && !op_resolution_select) begin
                result_low_nibble <= ladder_code[3:0];
            end else if (wr_low) begin
                result_low_nibble <=
                    wd[adc_seq_pkg::LOW_NIB_LO +: 4];
            end
            if (wr_low) begin
                divider_high_bit <= wd[adc_seq_pkg::LOW_DIV];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            adc_result_high <= adc_seq_pkg::RST_HIGH;
        end else if (ce) begin
            if (finish && !op_cmp) begin
                adc_result_high <= ladder_code[11:4];
            end else if (wr_high) begin
                adc_result_high <= wd;
            end
        end
    end

    // ************************************************
    // Analog side strobes and interrupt
    // ************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            channel_sel <= 4'h0;
            ladder_enable <= 1'b0;
            offset_comp <= 1'b0;
            result_strobe <= 1'b0;
        end else if (ce) begin
            channel_sel <= input_select;
            ladder_enable <= (next_state == adc_seq_pkg::ST_RUN);
            offset_comp <= offset_comp_enable;
            result_strobe <= finish;
        end
    end

    assign irq = irq_enable & done_flag;

    // ************************************************
    // Checks
    // ************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            run_len <= 8'h00;
            op_len <= 8'h00;
        end else if (ce) begin
            if (start_req) begin
                run_len <= 8'h00;
                op_len <= load_len;
            end else if (running) begin
                run_len <= run_len + 8'h01;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_begin;
        start_req && ce;
    endsequence
    sequence s_active;
        running && ladder_enable;
    endsequence

    property p_start;
        s_begin |=> s_active;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not begin an operation");

    property p_len;
        finish && ce |-> run_len == op_len - 8'h01;
    endproperty
    a_len: assert property (p_len)
        else $error("operation length differs from computed time");

    property p_self_clear;
        finish && ce |=> !running && !ladder_enable && result_strobe;
    endproperty
    a_self_clear: assert property (p_self_clear)
        else $error("start bit not cleared at completion");

    property p_abort;
        abort && ce |=> !running
            && (done_flag == ($past(done_flag)
            && $past(wd[adc_seq_pkg::CTL_DONE])));
    endproperty
    a_abort: assert property (p_abort)
        else $error("halt did not stop the operation");

    property p_done_set;
        finish && ce |=> done_flag;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("end flag not set at completion");

    property p_done_clear;
        wr_ctl && ce && !wd[adc_seq_pkg::CTL_DONE] && !finish |=> !done_flag;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("end flag not cleared by write of zero");

    property p_irq;
        finish && ce && irq_enable && !wr_ctl |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised at completion");

    property p_high;
        finish && ce && !op_cmp
            |=> adc_result_high == $past(ladder_code[11:4]);
    endproperty
    a_high: assert property (p_high)
        else $error("high result not captured");

    property p_low_kept;
        finish && ce && op_resolution_select && !op_cmp && !wr_low
            |=> $stable(result_low_nibble);
    endproperty
    a_low_kept: assert property (p_low_kept)
        else $error("low result changed in 8-bit mode");

    property p_cmp_bit;
        finish && ce && op_cmp |=> result_low_nibble[3] == $past(comp_level);
    endproperty
    a_cmp_bit: assert property (p_cmp_bit)
        else $error("compare outcome not stored in bit 7");

endmodule // adc_control_sequencer
`default_nettype wire

// File: tb/analog_front_model.sv
// Behavioural analog multiplexer, reference ladder and comparator
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
    input wire logic clk, // System clock
    input wire logic [191:0] levels, // Input levels, 12 bits per input
    input wire logic [3:0] channel_sel, // Selected input
    input wire logic ladder_enable, // Ladder powered
    input wire logic [11:0] ladder_code, // Reference code
    output logic comp_out = 1'b0 // High when input above reference
);
    logic [11:0] ain;
    assign ain = levels[channel_sel*12 +: 12];
    // An unpowered ladder gives no decision, so the output keeps moving
    always @(posedge clk) begin
        if (ladder_enable) begin
            // Input sits half a step above its code, so ties never occur
            comp_out <= {ain, 1'b1} > {ladder_code, 1'b0};
        end else begin
            comp_out <= ~comp_out;
        end
    end
endmodule // analog_front_model
`default_nettype wire

// File: tb/tb_adc_control_sequencer.sv
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_sequencer;
    logic clk, rst_b, read, write, waitrequest, comp_out, ladder_enable;
    logic offset_comp, result_strobe, irq, ce;
    logic [16:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] channel_sel;
    logic [11:0] ladder_code;
    logic [191:0] levels;
    logic [7:0] q, hi, lo;
    int failures, total_checks, n;
    adc_control_sequencer u_dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
        .waitrequest(waitrequest), .comp_out(comp_out),
        .channel_sel(channel_sel), .ladder_enable(ladder_enable),
        .ladder_code(ladder_code), .offset_comp(offset_comp),
        .result_strobe(result_strobe), .irq(irq));
    analog_front_model u_front (.clk(clk), .levels(levels),
        .channel_sel(channel_sel), .ladder_enable(ladder_enable),
        .ladder_code(ladder_code), .comp_out(comp_out));
    task automatic chk(input string what, input logic [11:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Register r counts from the control register; 4 is unmapped
    task automatic acc(input logic wr, input logic [2:0] r,
                       input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        address <= {adc_seq_pkg::IDX_CONTROL + 15'(r), 2'b00};
        write <= wr;
        read <= !wr;
        writedata <= {24'h0, d};
        // Waitrequest and read data as they stand at the edge
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        if (waitrequest !== 1'b0) begin
            failures++;
            $display("ERROR waitrequest expected 0 seen 1");
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    function automatic int len(int base, int c, bit dbl);
        len = ((base + (1 << c) - 1) >> c) + 2;
        if (dbl) len = 2 * len;
    endfunction
    task automatic run(input logic [7:0] ctl, input int exp_len);
        int s;
        s = 0;
        n = 0;
        acc(1, 0, ctl);
        do begin
            @(negedge clk);
            if (ladder_enable === 1'b1) n++;
            if (result_strobe === 1'b1) s++;
        end while ((n == 0 || ladder_enable !== 1'b0) && n < 400);
        @(negedge clk);
        if (result_strobe === 1'b1) s++;
        chk("channel_sel", ctl[7:4], channel_sel);
        chk("length", 12'(exp_len), 12'(n));
        chk("strobes", 12'h1, 12'(s));
        chk("irq", ctl[0], irq);
        acc(0, 0, 8'h0);
        chk("control", ctl & 8'hf9 | 8'h02, q);
        acc(1, 0, ctl & 8'hf9);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        void'($urandom(32'h8095));
        for (int i = 0; i < 16; i++) levels[i*12 +: 12] = 12'($urandom);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            acc(0, 3'(i), 8'h0);
            chk("reset value", 12'h0, q);
        end
        run(8'h35, len(52, 0, 1));
        acc(0, 3, 8'h0);
        hi = q;
        acc(0, 2, 8'h0);
        chk("result", levels[36 +: 12], {hi, q[7:4]});
        run(8'h34, len(52, 0, 0));
        $display("converter test done");
        for (int c = 0; c < 8; c++) begin
            lo = {4'(c + 5), 3'h0, 1'(c >> 2)};
            acc(1, 2, lo);
            acc(1, 1, {6'h10, 2'(c)});
            run({4'(c), 4'h4}, len(32, c, 0));
            acc(0, 2, 8'h0);
            chk("low kept", lo, q);
        end
        acc(1, 2, 8'h01);
        acc(1, 1, 8'h03);
        run(8'hf4, len(52, 7, 1));
        run(8'hf4, len(52, 7, 0));
        $display("divider test done");
        acc(1, 2, 8'h00);
        acc(1, 1, 8'h04);
        for (int ch = 0; ch < 16; ch++) begin
            hi = 8'($urandom);
            acc(1, 3, hi);
            run({4'(ch), 4'hc}, len(28, 0, 0));
            acc(0, 2, 8'h0);
            chk("compare", levels[ch*12 +: 12] >= {hi, 4'h0}, q[7]);
        end
        chk("offset_comp", 12'h1, offset_comp);
        acc(1, 1, 8'h00);
        acc(1, 0, 8'h04);
        // Clock enable low must freeze the running operation
        ce <= 1'b0;
        repeat (60) @(posedge clk);
        ce <= 1'b1;
        @(negedge clk);
        chk("frozen", 12'h1, ladder_enable);
        acc(1, 0, 8'h00);
        repeat (2) @(negedge clk);
        chk("abort", 12'h0, ladder_enable);
        acc(0, 0, 8'h0);
        chk("no done", 12'h0, q);
        // Reset in mid-operation
        acc(1, 0, 8'h05);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk("reset stop", 12'h0, ladder_enable);
        acc(0, 0, 8'h0);
        chk("reset control", 12'h0, q);
        $display("compare and abort test done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
    task automatic summarize;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
endmodule // tb_adc_control_sequencer
`default_nettype wire
